// File: rtl/dts_pkg.sv
`default_nettype none
package dts_pkg;
    // register indexes; byte address is four times the index
    localparam int         IDX_W      = 8;
    localparam logic [7:0] IDX_CTRL1  = 8'h20;
    localparam logic [7:0] IDX_STATUS = 8'h21;
    localparam logic [7:0] IDX_COUNT  = 8'h22;
    localparam logic [7:0] IDX_SHARED = 8'h27;
    localparam logic [7:0] IDX_WIN    = 8'h28;
    localparam int         NUM_CMP    = 4;
    // debug_control_one fields
    localparam int C1_ARM   = 7;
    localparam int C1_TRACE = 5;
    localparam int C1_BRK   = 3;
    // debug_status fields
    localparam int ST_TBF   = 7;
    // comparator_control fields
    localparam int CC_SZE   = 7;
    localparam int CC_NDB   = 6;
    localparam int CC_TAG   = 5;
    localparam int CC_BRK   = 4;
    localparam int CC_RW    = 3;
    localparam int CC_RWE   = 2;
    localparam int CC_EN    = 0;
    // window byte offsets
    localparam logic [2:0] WOFF_CTL = 3'h0;
    localparam logic [2:0] WOFF_AH  = 3'h1;
    localparam logic [2:0] WOFF_AM  = 3'h2;
    localparam logic [2:0] WOFF_AL  = 3'h3;
    localparam logic [2:0] WOFF_DH  = 3'h4;
    localparam logic [2:0] WOFF_DL  = 3'h5;
    localparam logic [2:0] WOFF_MH  = 3'h6;
    localparam logic [2:0] WOFF_ML  = 3'h7;
    // trace buffer depth in lines
    localparam logic [6:0] TRACE_LINES = 7'h40;
    // reset values
    localparam logic [6:0] CTRL1_RST = 7'h00;
    localparam logic [3:0] SC_RST    = 4'h0;
    // sequencer state flag codes
    localparam logic [2:0] SSF_S0  = 3'h0;
    localparam logic [2:0] SSF_S1  = 3'h1;
    localparam logic [2:0] SSF_S2  = 3'h2;
    localparam logic [2:0] SSF_S3  = 3'h3;
    localparam logic [2:0] SSF_FIN = 3'h4;
    // sequencer states, gray along state0-1-2-3-final
    typedef enum logic [2:0] {
        SQ_IDLE = 3'b000,
        SQ_S1   = 3'b001,
        SQ_S2   = 3'b011,
        SQ_S3   = 3'b010,
        SQ_FIN  = 3'b110
    } dts_seq_type;
    // one monitored bus cycle
    typedef struct packed {
        logic        valid;
        logic        rd;
        logic        byte_sz;
        logic [23:0] addr;
        logic [15:0] data;
    } dts_mon_type;
endpackage
`default_nettype wire

// File: rtl/dts_top.sv
`timescale 1ns/1ps
`default_nettype none
module dts_top
#(
    parameter int PADDR_W = 12
)
(
    // clock and resets
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 sys_reset_n,
    // apb slave
    input  wire logic [PADDR_W-1:0]   paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // monitored bus and execution tags
    input  wire dts_pkg::dts_mon_type mon,
    input  wire logic [3:0]           exec_tag,
    // core side
    output logic                      brk_request,
    output logic                      dbg_armed
);
    import dts_pkg::*;

    // config state
    logic [6:0]  ctrl1_ff;
    logic [6:0]  nxt_ctrl1;
    logic [3:0]  sc_ff     [3];
    logic [3:0]  nxt_sc    [3];
    logic [7:0]  cmp_ctl_ff [NUM_CMP];
    logic [7:0]  nxt_cmp_ctl[NUM_CMP];
    logic [23:0] cmp_adr_ff [NUM_CMP];
    logic [23:0] nxt_cmp_adr[NUM_CMP];
    logic [15:0] cmp_dat_ff [NUM_CMP];
    logic [15:0] nxt_cmp_dat[NUM_CMP];
    logic [15:0] cmp_msk_ff [NUM_CMP];
    logic [15:0] nxt_cmp_msk[NUM_CMP];
    // session state
    logic        arm_ff;
    logic        nxt_arm;
    dts_seq_type seq_ff;
    dts_seq_type nxt_seq;
    logic [2:0]  ssf_ff;
    logic [2:0]  nxt_ssf;
    logic        tbf_ff;
    logic        nxt_tbf;
    logic [6:0]  cnt_ff;
    logic [6:0]  nxt_cnt;
    logic [3:0]  mflag_ff;
    logic [3:0]  nxt_mflag;
    logic [3:0]  tag_ff;
    logic [3:0]  nxt_tag;
    logic        brk_ff;
    logic        nxt_brk;
    // bus answer state
    logic        pready_ff;
    logic        nxt_pready;
    logic        pslverr_ff;
    logic        nxt_pslverr;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    // decode and match wires
    logic [7:0]  idx;
    logic [1:0]  bank;
    logic        wr_en;
    logic [3:0]  hit;
    logic [3:0]  imm;
    logic [3:0]  tag_set;
    logic [7:0]  rd_val;

    assign idx   = paddr[IDX_W+1:2];
    assign bank  = ctrl1_ff[1:0];
    assign wr_en = psel & penable & pwrite & pready_ff;

    // register present at index for current bank
    function automatic logic reg_mapped(input logic [7:0] i, input logic [1:0] b);
        logic win;
        win = (i >= IDX_WIN) && (i < IDX_WIN + 8'h08);
        return (i == IDX_CTRL1) || (i == IDX_STATUS) || (i == IDX_COUNT)
            || (i == IDX_SHARED) || (win && (!b[0] || (i[2:0] < WOFF_DH)));
    endfunction

    // state flag value of a sequencer state
    function automatic logic [2:0] ssf_of(input dts_seq_type s);
        logic [2:0] r;
        r = SSF_S0;
        unique case (s)
            SQ_IDLE: r = SSF_S0;
            SQ_S1:   r = SSF_S1;
            SQ_S2:   r = SSF_S2;
            SQ_S3:   r = SSF_S3;
            SQ_FIN:  r = SSF_FIN;
        endcase
        return r;
    endfunction

    // destination of a match on channel ch; SQ_IDLE means no move
    function automatic dts_seq_type dest_of(input dts_seq_type s, input logic [3:0] c,
                                            input logic [1:0] ch);
        dts_seq_type d;
        d = SQ_IDLE;
        if (s == SQ_S1)
        begin
            case (c)
                4'h7: d = (ch == 2'h1) ? SQ_S3 : (ch == 2'h0) ? SQ_FIN : SQ_IDLE;
                4'h8: d = (ch == 2'h0) ? SQ_S2 : (ch == 2'h2) ? SQ_S3 : SQ_IDLE;
                4'h9: d = (ch == 2'h2) ? SQ_S3 : (ch == 2'h0) ? SQ_FIN : SQ_IDLE;
                4'hA: d = (ch == 2'h1) ? SQ_S2 : (ch == 2'h3) ? SQ_S3 : SQ_IDLE;
                4'hB: d = (ch == 2'h3) ? SQ_S3 : (ch == 2'h1) ? SQ_FIN : SQ_IDLE;
                4'hC: d = (ch != 2'h3) ? SQ_S2 : SQ_IDLE;
                4'hD, 4'hE, 4'hF: d = SQ_IDLE;
                default: d = SQ_S2;
            endcase
        end
        else if (s == SQ_S2)
        begin
            case (c)
                4'h0: d = SQ_S1;
                4'h1: d = SQ_S3;
                4'h2: d = SQ_FIN;
                4'h3: d = (ch == 2'h3) ? SQ_S1 : SQ_IDLE;
                4'h4: d = (ch == 2'h3) ? SQ_S3 : SQ_IDLE;
                default: d = SQ_IDLE;
            endcase
        end
        else if (s == SQ_S3)
        begin
            case (c)
                4'h0: d = SQ_S1;
                4'h1: d = SQ_S2;
                4'h2: d = SQ_FIN;
                default: d = SQ_IDLE;
            endcase
        end
        return d;
    endfunction

    // pick the winner among simultaneous matches
    function automatic dts_seq_type pick(input dts_seq_type s, input logic [3:0] c,
                                         input logic [3:0] h);
        dts_seq_type d;
        dts_seq_type t;
        logic        fin;
        d   = SQ_IDLE;
        fin = 1'b0;
        for (int i = NUM_CMP - 1; i >= 0; i--)
        begin
            t = dest_of(s, c, 2'(i));
            if (h[i] && (t == SQ_FIN))
                fin = 1'b1;
            else if (h[i] && (t != SQ_IDLE))
                d = t;
        end
        return fin ? SQ_FIN : d;
    endfunction

    // per-comparator match logic
    for (genvar g = 0; g < NUM_CMP; g++)
    begin : g_cmp
        logic       aeq;
        logic       rw_ok;
        logic       dat_ok;
        logic       sz_ok;
        logic [7:0] cc;
        assign cc     = cmp_ctl_ff[g];
        assign aeq    = mon.valid & (mon.addr == cmp_adr_ff[g]);
        assign rw_ok  = ~cc[CC_RWE] | (cc[CC_RW] == mon.rd);
        assign dat_ok = (g % 2 != 0)
                      | ((|((mon.data ^ cmp_dat_ff[g]) & cmp_msk_ff[g])) == cc[CC_NDB]);
        assign sz_ok  = (g % 2 == 0) | ~cc[CC_SZE] | (cc[CC_NDB] == mon.byte_sz);
        // tagged channels fire when the tagged opcode executes
        assign hit[g] = arm_ff & cc[CC_EN] & (cc[CC_TAG] ? (tag_ff[g] & exec_tag[g])
                      : (aeq & rw_ok & dat_ok & sz_ok));
        assign imm[g] = hit[g] & cc[CC_BRK];
        assign tag_set[g] = arm_ff & cc[CC_EN] & cc[CC_TAG] & aeq;
    end

    // config next values
    always_comb
    begin
        nxt_ctrl1   = ctrl1_ff;
        nxt_sc      = sc_ff;
        nxt_cmp_ctl = cmp_ctl_ff;
        nxt_cmp_adr = cmp_adr_ff;
        nxt_cmp_dat = cmp_dat_ff;
        nxt_cmp_msk = cmp_msk_ff;
        if (wr_en && (idx == IDX_CTRL1))
            nxt_ctrl1 = pwdata[6:0];
        if (wr_en && !arm_ff && (idx == IDX_SHARED) && (bank != 2'h3))
            nxt_sc[bank] = pwdata[3:0];
        if (wr_en && !arm_ff && reg_mapped(idx, bank) && (idx >= IDX_WIN))
        begin
            unique case (idx[2:0])
                WOFF_CTL: nxt_cmp_ctl[bank]        = pwdata[7:0];
                WOFF_AH:  nxt_cmp_adr[bank][23:16] = pwdata[7:0];
                WOFF_AM:  nxt_cmp_adr[bank][15:8]  = pwdata[7:0];
                WOFF_AL:  nxt_cmp_adr[bank][7:0]   = pwdata[7:0];
                WOFF_DH:  nxt_cmp_dat[bank][15:8]  = pwdata[7:0];
                WOFF_DL:  nxt_cmp_dat[bank][7:0]   = pwdata[7:0];
                WOFF_MH:  nxt_cmp_msk[bank][15:8]  = pwdata[7:0];
                WOFF_ML:  nxt_cmp_msk[bank][7:0]   = pwdata[7:0];
            endcase
        end
        if (!sys_reset_n)
        begin
            nxt_ctrl1 = CTRL1_RST;
            for (int i = 0; i < 3; i++)
                nxt_sc[i] = SC_RST;
        end
    end

    // config registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl1_ff <= CTRL1_RST;
            for (int i = 0; i < 3; i++)
                sc_ff[i] <= SC_RST;
            for (int i = 0; i < NUM_CMP; i++)
            begin
                cmp_ctl_ff[i] <= 8'h00;
                cmp_adr_ff[i] <= 24'h000000;
                cmp_dat_ff[i] <= 16'h0000;
                cmp_msk_ff[i] <= 16'h0000;
            end
        end
        else
        begin
            ctrl1_ff   <= nxt_ctrl1;
            sc_ff      <= nxt_sc;
            cmp_ctl_ff <= nxt_cmp_ctl;
            cmp_adr_ff <= nxt_cmp_adr;
            cmp_dat_ff <= nxt_cmp_dat;
            cmp_msk_ff <= nxt_cmp_msk;
        end
    end

    // session next values
    always_comb
    begin
        dts_seq_type tgt;
        logic        ends;
        logic        full;
        tgt       = pick(seq_ff, (seq_ff == SQ_S1) ? sc_ff[0]
                                : (seq_ff == SQ_S2) ? sc_ff[1] : sc_ff[2], hit);
        ends      = arm_ff & ((|imm) | ((seq_ff == SQ_FIN)
                  & (~ctrl1_ff[C1_TRACE] | tbf_ff)));
        full      = 1'b0;
        nxt_arm   = arm_ff;
        nxt_seq   = seq_ff;
        nxt_ssf   = ssf_ff;
        nxt_tbf   = tbf_ff;
        nxt_cnt   = cnt_ff;
        nxt_mflag = mflag_ff | hit;
        nxt_brk   = 1'b0;
        for (int i = 0; i < NUM_CMP; i++)
            nxt_tag[i] = tag_set[i] | (tag_ff[i] & arm_ff & ~exec_tag[i]);
        // trace line count wraps at buffer depth
        if (arm_ff && ctrl1_ff[C1_TRACE] && mon.valid)
        begin
            full    = (cnt_ff == TRACE_LINES - 7'h01);
            nxt_cnt = full ? 7'h00 : cnt_ff + 7'h01;
        end
        // sequencer step or internal end of session
        if (ends)
        begin
            nxt_arm = 1'b0;
            nxt_seq = SQ_IDLE;
            nxt_ssf = SSF_S0;
            nxt_brk = ctrl1_ff[C1_BRK];
        end
        else if (arm_ff && (tgt != SQ_IDLE))
        begin
            nxt_seq = tgt;
            nxt_ssf = ssf_of(tgt);
        end
        // software arm and disarm
        if (wr_en && (idx == IDX_CTRL1))
        begin
            nxt_arm = pwdata[C1_ARM];
            if (pwdata[C1_ARM])
            begin
                nxt_seq   = SQ_S1;
                nxt_ssf   = SSF_S1;
                nxt_tbf   = 1'b0;
                nxt_cnt   = 7'h00;
                nxt_mflag = 4'h0;
                nxt_tag   = 4'h0;
            end
            else
                nxt_seq = SQ_IDLE;
        end
        if (full)
            nxt_tbf = 1'b1;
        // system reset other than power-on keeps trace full
        if (!sys_reset_n)
        begin
            nxt_arm   = 1'b0;
            nxt_seq   = SQ_IDLE;
            nxt_ssf   = SSF_S0;
            nxt_cnt   = 7'h00;
            nxt_mflag = 4'h0;
            nxt_tag   = 4'h0;
            nxt_brk   = 1'b0;
            nxt_tbf   = tbf_ff;
        end
    end

    // session registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            arm_ff   <= 1'b0;
            seq_ff   <= SQ_IDLE;
            ssf_ff   <= SSF_S0;
            tbf_ff   <= 1'b0;
            cnt_ff   <= 7'h00;
            mflag_ff <= 4'h0;
            tag_ff   <= 4'h0;
            brk_ff   <= 1'b0;
        end
        else
        begin
            arm_ff   <= nxt_arm;
            seq_ff   <= nxt_seq;
            ssf_ff   <= nxt_ssf;
            tbf_ff   <= nxt_tbf;
            cnt_ff   <= nxt_cnt;
            mflag_ff <= nxt_mflag;
            tag_ff   <= nxt_tag;
            brk_ff   <= nxt_brk;
        end
    end

    // read mux
    always_comb
    begin
        rd_val = 8'h00;
        if (idx == IDX_CTRL1)
            rd_val = {arm_ff, ctrl1_ff};
        else if (idx == IDX_STATUS)
            rd_val = {tbf_ff, 4'h0, ssf_ff};
        else if (idx == IDX_COUNT)
            rd_val = {1'b0, cnt_ff};
        else if (idx == IDX_SHARED)
            rd_val = (bank == 2'h3) ? {4'h0, mflag_ff} : {4'h0, sc_ff[bank]};
        else if (reg_mapped(idx, bank))
        begin
            unique case (idx[2:0])
                WOFF_CTL: rd_val = cmp_ctl_ff[bank];
                WOFF_AH:  rd_val = cmp_adr_ff[bank][23:16];
                WOFF_AM:  rd_val = cmp_adr_ff[bank][15:8];
                WOFF_AL:  rd_val = cmp_adr_ff[bank][7:0];
                WOFF_DH:  rd_val = cmp_dat_ff[bank][15:8];
                WOFF_DL:  rd_val = cmp_dat_ff[bank][7:0];
                WOFF_MH:  rd_val = cmp_msk_ff[bank][15:8];
                WOFF_ML:  rd_val = cmp_msk_ff[bank][7:0];
            endcase
        end
    end

    // apb answer: one wait state, error on unmapped index
    always_comb
    begin
        nxt_pready  = psel & penable & ~pready_ff;
        nxt_pslverr = nxt_pready & ~reg_mapped(idx, bank);
        nxt_prdata  = (nxt_pready && !pwrite) ? {24'h000000, rd_val} : 32'h00000000;
    end

    // apb answer registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end
        else
        begin
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff  <= nxt_prdata;
        end
    end

    // outputs from flip-flops
    assign pready      = pready_ff;
    assign pslverr     = pslverr_ff;
    assign prdata      = prdata_ff;
    assign brk_request = brk_ff;
    assign dbg_armed   = arm_ff;
endmodule
`default_nettype wire

// File: tb/dts_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module dts_core_model
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // core side of the trigger unit
    input  wire logic       brk_request,
    input  wire logic [3:0] exec_fire,
    output logic      [3:0] exec_tag,
    output var int          brk_seen
);
    // a tagged opcode reaches execution one cycle after the bench asks
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            exec_tag <= 4'h0;
        else
            exec_tag <= exec_fire;
    // the core takes every breakpoint request pulse
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            brk_seen <= 0;
        else if (brk_request)
            brk_seen <= brk_seen + 1;
endmodule
`default_nettype wire

// File: tb/dts_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dts_top_checker
    import dts_pkg::*;
#(
    parameter int PADDR_W = 12
)
(
    // clock and resets
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               sys_reset_n,
    // apb
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    // core side
    input wire logic               brk_request,
    input wire logic               dbg_armed
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // committed write to control one
    logic c1_wr;
    assign c1_wr = psel && penable && pready && pwrite && (paddr[9:2] == IDX_CTRL1);
    // apb answer timing
    chk_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("pready without access");
    chk_err_answer: assert property (pslverr |-> pready)
        else $error("pslverr outside answer");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    // arming and session end
    chk_arm_follow: assert property (c1_wr && sys_reset_n |=> dbg_armed == $past(pwdata[C1_ARM]))
        else $error("armed does not follow control write");
    chk_sysrst_disarm: assert property (!sys_reset_n |=> !dbg_armed)
        else $error("armed survives system reset");
    chk_brk_pulse: assert property (brk_request |=> !brk_request)
        else $error("breakpoint request longer than one cycle");
    chk_brk_end: assert property (brk_request |-> !dbg_armed && $past(dbg_armed))
        else $error("breakpoint request without session end");
    // main scenarios
    cov_brk: cover property (brk_request);
    cov_err: cover property (pslverr);
    cov_soft_end: cover property ($fell(dbg_armed) && !brk_request);
endmodule
bind dts_top dts_top_checker #(.PADDR_W(PADDR_W)) chk_i (.pclk(pclk), .presetn(presetn),
    .sys_reset_n(sys_reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .brk_request(brk_request), .dbg_armed(dbg_armed));
`default_nettype wire

// File: tb/debug_trigger_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module debug_trigger_sequencer_bench;
    import dts_pkg::*;
    logic        pclk, presetn, sys_reset_n, psel, penable, pwrite;
    logic        pready, pslverr, brk_request, dbg_armed, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  exec_tag, exec_fire;
    logic [7:0]  rdat;
    logic [23:0] r;
    dts_mon_type mon;
    int          brk_seen, err_count, checks_done, b;
    // rows: sc1, sc2, enables, pulses, brk enable, expected flags
    localparam logic [23:0] ROWS [20] = '{
        24'h001211, 24'h011213, 24'h021210, 24'h031212, 24'h038211, 24'h048213,
        24'h703110, 24'h702113, 24'h801112, 24'h804113, 24'h802111,
        24'h904113, 24'h905100, 24'hA0A112, 24'hB08113, 24'hB0A110,
        24'hC07112, 24'hC08111, 24'hD0F111, 24'hF0F111};
    dts_top #(.PADDR_W(12)) uut (.pclk(pclk), .presetn(presetn), .sys_reset_n(sys_reset_n),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mon(mon),
        .exec_tag(exec_tag), .brk_request(brk_request), .dbg_armed(dbg_armed));
    dts_core_model core (.pclk(pclk), .presetn(presetn), .brk_request(brk_request),
        .exec_fire(exec_fire), .exec_tag(exec_tag), .brk_seen(brk_seen));
    // clock
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rdat = prdata[7:0];
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20)
            err_count++;
    endtask
    // monitored bus lines, one per cycle
    task automatic hit(input logic [23:0] a, input int cyc);
        @(posedge pclk);
        mon <= {1'b1, 1'b1, 1'b0, a, 16'h0};
        repeat (cyc) @(posedge pclk);
        mon <= '0;
    endtask
    task automatic setup(input logic [3:0] sc1, input logic [3:0] sc2, input logic [3:0] en,
                         input logic [7:0] ctl, input logic [7:0] arm);
        for (int c = 0; c < NUM_CMP; c++)
        begin
            xfer(1'b1, IDX_CTRL1, 8'(c));
            xfer(1'b1, IDX_WIN, en[c] ? ctl : 8'h00);
        end
        xfer(1'b1, IDX_CTRL1, 8'h00);
        xfer(1'b1, IDX_SHARED, {4'h0, sc1});
        xfer(1'b1, IDX_CTRL1, 8'h01);
        xfer(1'b1, IDX_SHARED, {4'h0, sc2});
        xfer(1'b1, IDX_CTRL1, arm);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog
    initial
    begin
        repeat (40000) @(posedge pclk);
        err_count++;
        final_report;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, exec_fire} = '0;
        sys_reset_n = 1'b1;
        mon = '0;
        err_count = 0;
        checks_done = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, IDX_STATUS, 8'h00);
        check("status reset", rdat & 8'h87, 8'h00);
        xfer(1'b0, 8'h10, 8'h00);
        check("unmapped err", {7'h0, rerr}, 8'h01);
        // every comparator watches one address, data masked off
        for (int c = 0; c < NUM_CMP; c++)
        begin
            xfer(1'b1, IDX_CTRL1, 8'(c));
            for (int o = 1; o < 8; o++)
                if (o < 4 || c % 2 == 0)
                    xfer(1'b1, IDX_WIN + 8'(o), o == 1 ? 8'h12 : o == 2 ? 8'h34 :
                         o == 3 ? 8'h56 : 8'h00);
        end
        xfer(1'b1, IDX_CTRL1, 8'h02);
        xfer(1'b0, IDX_WIN + 8'h01, 8'h00);
        check("bank c addr", rdat, 8'h12);
        xfer(1'b1, IDX_CTRL1, 8'h01);
        xfer(1'b0, IDX_WIN + 8'h04, 8'h00);
        check("bank b data err", {7'h0, rerr}, 8'h01);
        foreach (ROWS[i])
        begin
            r = ROWS[i];
            b = brk_seen;
            setup(r[23:20], r[19:16], r[15:12], 8'h01, r[4] ? 8'h88 : 8'h80);
            xfer(1'b0, IDX_STATUS, 8'h00);
            check("armed flags", rdat & 8'h87, 8'h01);
            repeat (r[11:8])
            begin
                hit(24'h123456, 1);
                repeat (2) @(posedge pclk);
            end
            repeat (4) @(posedge pclk);
            xfer(1'b0, IDX_STATUS, 8'h00);
            check("flags", rdat & 8'h87, {5'h0, r[2:0]});
            check("armed", {7'h0, dbg_armed}, {7'h0, r[2:0] != 3'h0});
            check("brk count", 8'(brk_seen - b), {7'h0, r[4] && r[2:0] == 3'h0});
            xfer(1'b1, IDX_CTRL1, 8'h00);
            xfer(1'b0, IDX_STATUS, 8'h00);
            check("kept flags", rdat & 8'h87, {5'h0, r[2:0]});
        end
        // locked registers while armed
        setup(4'hD, 4'h5, 4'h0, 8'h01, 8'h81);
        xfer(1'b1, IDX_SHARED, 8'h06);
        xfer(1'b0, IDX_SHARED, 8'h00);
        check("state2 code", rdat & 8'h0F, 8'h05);
        xfer(1'b1, IDX_STATUS, 8'hFF);
        xfer(1'b0, IDX_STATUS, 8'h00);
        check("status kept", rdat & 8'h87, 8'h01);
        xfer(1'b1, IDX_CTRL1, 8'h00);
        xfer(1'b0, IDX_SHARED, 8'h00);
        check("bank a code", rdat & 8'h0F, 8'h0D);
        // immediate break on a reserved code
        b = brk_seen;
        setup(4'hD, 4'h0, 4'h1, 8'h11, 8'h88);
        hit(24'h123456, 1);
        repeat (3) @(posedge pclk);
        check("break disarm", {7'h0, dbg_armed}, 8'h00);
        check("break request", 8'(brk_seen - b), 8'h01);
        // tagged match waits for execution
        setup(4'h7, 4'h0, 4'h1, 8'h21, 8'h80);
        hit(24'h123456, 1);
        repeat (3) @(posedge pclk);
        check("tag waits", {7'h0, dbg_armed}, 8'h01);
        exec_fire <= 4'h1;
        @(posedge pclk);
        exec_fire <= 4'h0;
        repeat (4) @(posedge pclk);
        check("tag fires", {7'h0, dbg_armed}, 8'h00);
        // final state with tracing waits for a full buffer before the break
        b = brk_seen;
        setup(4'h0, 4'h2, 4'h1, 8'h01, 8'hA8);
        hit(24'h123456, 1);
        repeat (2) @(posedge pclk);
        hit(24'h123456, 1);
        repeat (3) @(posedge pclk);
        check("trace holds final", {7'h0, dbg_armed}, 8'h01);
        check("trace no brk yet", 8'(brk_seen - b), 8'h00);
        hit(24'h000000, 62);
        repeat (3) @(posedge pclk);
        check("trace end disarm", {7'h0, dbg_armed}, 8'h00);
        check("trace end brk", 8'(brk_seen - b), 8'h01);
        // trace fill, system reset, re-arm
        setup(4'h0, 4'h0, 4'h0, 8'h00, 8'hA0);
        hit(24'h000000, 63);
        xfer(1'b0, IDX_STATUS, 8'h00);
        check("trace 63", rdat & 8'h80, 8'h00);
        hit(24'h000000, 1);
        xfer(1'b0, IDX_STATUS, 8'h00);
        check("trace 64", rdat & 8'h80, 8'h80);
        sys_reset_n <= 1'b0;
        @(posedge pclk);
        sys_reset_n <= 1'b1;
        xfer(1'b0, IDX_STATUS, 8'h00);
        check("full kept", rdat & 8'h80, 8'h80);
        check("sys disarm", {7'h0, dbg_armed}, 8'h00);
        xfer(1'b1, IDX_CTRL1, 8'h80);
        xfer(1'b0, IDX_STATUS, 8'h00);
        check("arm clears", rdat & 8'h87, 8'h01);
        final_report;
    end
endmodule
`default_nettype wire
